// ---- src/tsl_defs.svh ----
`ifndef TSL_DEFS_SVH
`define TSL_DEFS_SVH

// Register bus address width and word offsets.
`define TSL_AW          6
`define TSL_OFF_CTRL    6'h00
`define TSL_OFF_SLOT    6'h04
`define TSL_OFF_TXD     6'h08
`define TSL_OFF_RXS     6'h0c

// Control register fields.
`define TSL_B_EN        0
`define TSL_B_CLKOUT    1
`define TSL_B_CLKNEG    2
`define TSL_B_POUT      3
`define TSL_B_GENERIC   4
`define TSL_B_TXPOL     5
`define TSL_B_RXPOL     6
`define TSL_F_TXLEN     9:8
`define TSL_F_RXRATE    11:10
`define TSL_F_CLKSEL    15:12

// Slot window fields.
`define TSL_F_FIRST     6:0
`define TSL_F_LAST      14:8

// Receive status fields.
`define TSL_B_NEW       16
`define TSL_B_OVR       17

// Writable bits and reset values.
`define TSL_CTRL_MASK   32'h0000ff7f
`define TSL_SLOT_MASK   32'h00007f7f
`define TSL_TXD_MASK    32'h000000ff
`define TSL_CTRL_RST    32'h00000000
`define TSL_SLOT_RST    32'h00007f00
`define TSL_TXD_RST     32'h00000000

// Frame lengths: 32, 64 or 128 channels of eight bits.
`define TSL_LEN32       2'h0
`define TSL_LEN64       2'h1
`define TSL_LAST32      10'h0ff
`define TSL_LAST64      10'h1ff
`define TSL_LAST128     10'h3ff

// Bus answers and the own receive clock.
`define TSL_RESP_OKAY   2'h0
`define TSL_RESP_DECERR 2'h3
`define TSL_OWN_RX      3'h0

`endif

// ---- src/tsl_pkg.sv ----
`include "tsl_defs.svh"

package tsl_pkg;

    // Link configuration as seen by one direction of the port.
    typedef struct packed {
        logic       en;
        logic       pulse_out;
        logic       generic;
        logic       pol_high;
        logic [1:0] len;
        logic [6:0] first;
        logic [6:0] last;
        logic [7:0] data;
    } tsl_cfg_t;

    // Register bus write channel states.
    typedef enum logic [1:0] {
        TSL_WR_IDLE = 2'b00,
        TSL_WR_ADDR = 2'b01,
        TSL_WR_DATA = 2'b10,
        TSL_WR_RESP = 2'b11
    } tsl_wr_st_t;

    // Index of the last bit of a frame for a length code.
    function automatic logic [9:0] tsl_frame_last(input logic [1:0] len);
        if (len == `TSL_LEN32) begin
            return `TSL_LAST32;
        end else if (len == `TSL_LEN64) begin
            return `TSL_LAST64;
        end
        return `TSL_LAST128;
    endfunction

    // True when a bit index falls in the assigned slots of an enabled link.
    function automatic logic tsl_in_window(input logic [9:0] idx, input tsl_cfg_t c);
        return c.en && (idx[9:3] >= c.first) && (idx[9:3] <= c.last);
    endfunction

    // Byte-lane merge of a register write, limited to writable bits.
    function automatic logic [31:0] tsl_wmerge(input logic [31:0] old_v,
                                               input logic [31:0] new_v,
                                               input logic [3:0]  strb,
                                               input logic [31:0] mask);
        logic [31:0] r;
        r = old_v;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                r[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        return r & mask;
    endfunction

endpackage

// ---- src/tsl_frm_if.sv ----
`timescale 1ns/100ps

// Carries configuration in and frame timing out of one framer.
interface tsl_frm_if;
    import tsl_pkg::*;
    tsl_cfg_t   cfg;
    logic       pulse_in;
    tsl_cfg_t   scfg;
    logic       rst_n;
    logic [9:0] cnt_q;
    logic [9:0] cnt_d;
    logic       pulse_q;

    modport framer (
        input  cfg,
        input  pulse_in,
        output scfg,
        output rst_n,
        output cnt_q,
        output cnt_d,
        output pulse_q
    );

    modport user (
        output cfg,
        output pulse_in,
        input  scfg,
        input  rst_n,
        input  cnt_q,
        input  cnt_d,
        input  pulse_q
    );
endinterface

// ---- src/tsl_framer.sv ----
`timescale 1ns/100ps

// Bit and slot counter of one direction, running on that direction's clock.
module tsl_framer
    import tsl_pkg::*;
(
    input  wire logic clk,
    input  wire logic aresetn,
    tsl_frm_if.framer frm
);

    logic [1:0] rst_sync_q;
    tsl_cfg_t   cfg_meta_q;
    tsl_cfg_t   cfg_q;
    logic [9:0] cnt_q;
    logic [9:0] cnt_d;
    logic [9:0] last;
    logic       act_lvl;
    logic       seen;
    logic       pulse_q;

    // Reset and the quasi-static configuration cross into the link clock.
    always_ff @(posedge clk) begin
        rst_sync_q <= {rst_sync_q[0], aresetn};
        cfg_meta_q <= frm.cfg;
        cfg_q      <= cfg_meta_q;
    end

    // Framed-pulse mode is active low; generic mode follows the polarity bit.
    assign act_lvl = cfg_q.generic ? cfg_q.pol_high : 1'b0;
    assign seen    = (frm.pulse_in == act_lvl);
    assign last    = tsl_frame_last(cfg_q.len);

    // A seen pulse makes the next bit bit zero of slot zero, unless the pulse is generated (pulse_out).
    always_comb begin
        if (!rst_sync_q[1] || !cfg_q.en) begin
            cnt_d = 10'h000;
        end else if (!cfg_q.pulse_out && seen) begin
            cnt_d = 10'h000;
        end else if (cnt_q >= last) begin
            cnt_d = 10'h000;
        end else begin
            cnt_d = cnt_q + 10'h001;
        end
    end

    // A generated pulse stands over the last bit of each frame.
    always_ff @(posedge clk) begin
        if (!rst_sync_q[1]) begin
            cnt_q   <= 10'h000;
            pulse_q <= 1'b1;
        end else begin
            cnt_q   <= cnt_d;
            pulse_q <= (cfg_q.en && cfg_q.pulse_out && cnt_d == last) ?
                       act_lvl : ~act_lvl;
        end
    end

    assign frm.scfg    = cfg_q;
    assign frm.rst_n   = rst_sync_q[1];
    assign frm.cnt_q   = cnt_q;
    assign frm.cnt_d   = cnt_d;
    assign frm.pulse_q = pulse_q;

endmodule

// ---- src/tsl_port.sv ----
`timescale 1ns/100ps
`include "tsl_defs.svh"

// Notes on behaviour
// - Data pin released outside slots or link off.
// - Transmit data launched on transmit clock and pulse.
// - Receive data captured on receive clock and pulse.
// - Transmit clock pin direction set per link.
// - Output transmit clock from receive or reference clocks.
// - Transmit clock active edge set by polarity bit.
// - Transmit frame pulse pin direction set per link.
// - Generated pulse derives from own transmit clock.
// - Framed mode: low pulse bounds 32/64/128 channels.
// - Generic transmit pulse polarity programmable, marks start.
// - Generic receive pulse polarity programmable, marks start.
// - Receive frame timing follows expected clock setting.
// - Reference clocks routed internally to transmit clock.
module tsl_port
    import tsl_pkg::*;
(
    input  wire logic                aclk,
    input  wire logic                aresetn,
    input  wire logic [`TSL_AW-1:0]  s_axi_awaddr,
    input  wire logic                s_axi_awvalid,
    output logic                     s_axi_awready,
    input  wire logic [31:0]         s_axi_wdata,
    input  wire logic [3:0]          s_axi_wstrb,
    input  wire logic                s_axi_wvalid,
    output logic                     s_axi_wready,
    output logic [1:0]               s_axi_bresp,
    output logic                     s_axi_bvalid,
    input  wire logic                s_axi_bready,
    input  wire logic [`TSL_AW-1:0]  s_axi_araddr,
    input  wire logic                s_axi_arvalid,
    output logic                     s_axi_arready,
    output logic [31:0]              s_axi_rdata,
    output logic [1:0]               s_axi_rresp,
    output logic                     s_axi_rvalid,
    input  wire logic                s_axi_rready,
    input  wire logic [7:0]          rx_link_clock,
    input  wire logic [3:0]          dejittered_ref_clock,
    input  wire logic                tdm_rx_serial_in,
    input  wire logic                rx_frame_pulse_pin,
    input  wire logic                tx_link_clock_i,
    output logic                     tx_link_clock_o,
    output logic                     tx_link_clock_oe,
    input  wire logic                tx_frame_pulse_pin_i,
    output logic                     tx_frame_pulse_pin_o,
    output logic                     tx_frame_pulse_pin_oe,
    output logic                     tdm_tx_serial_out_o,
    output logic                     tdm_tx_serial_out_oe
);

    // Register bus state.
    tsl_wr_st_t          wr_st_q;
    tsl_wr_st_t          wr_st_d;
    logic [`TSL_AW-1:0]  waddr_q;
    logic [31:0]         wdata_q;
    logic [3:0]          wstrb_q;
    logic [1:0]          bresp_q;
    logic                rvalid_q;
    logic [31:0]         rdata_q;
    logic [1:0]          rresp_q;
    logic                aw_hs;
    logic                w_hs;
    logic                ar_hs;
    logic                wr_go;
    logic [`TSL_AW-1:0]  wr_addr;
    logic [31:0]         wr_data;
    logic [3:0]          wr_strb;
    logic                w_ctrl;
    logic                w_slot;
    logic                w_txd;
    logic                w_rxs;
    logic                w_map;
    logic [31:0]         rd_data;
    logic [1:0]          rd_resp;

    // Software-visible registers.
    logic [31:0]         ctrl_q;
    logic [31:0]         slot_q;
    logic [31:0]         txd_q;
    logic [7:0]          rxs_byte_q;
    logic [6:0]          rxs_slot_q;
    logic                new_q;
    logic                ovr_q;
    logic [2:0]          rx_tgl_s_q;
    logic                rx_evt;
    logic                clr_new;
    logic                clr_ovr;

    // Clock selection.
    logic [3:0]          clk_sel;
    logic                tx_src_clk;
    logic                tx_line_clock;
    logic                rx_line_clock;

    // Transmit link side.
    logic                tx_do_q;
    logic                tx_oe_q;
    logic                fp_oe_q;

    // Receive link side.
    logic [7:0]          rx_sh_q;
    logic [7:0]          rx_byte_q;
    logic [6:0]          rx_slot_q;
    logic                rx_tgl_q;

    tsl_frm_if tx_frm();
    tsl_frm_if rx_frm();

    // Write channel handshakes; address and data may come in either order.
    assign s_axi_awready = (wr_st_q == TSL_WR_IDLE) || (wr_st_q == TSL_WR_DATA);
    assign s_axi_wready  = (wr_st_q == TSL_WR_IDLE) || (wr_st_q == TSL_WR_ADDR);
    assign s_axi_bvalid  = (wr_st_q == TSL_WR_RESP);
    assign s_axi_bresp   = bresp_q;
    assign aw_hs         = s_axi_awvalid && s_axi_awready;
    assign w_hs          = s_axi_wvalid && s_axi_wready;

    // Write channel sequencing.
    always_comb begin
        case (wr_st_q)
            TSL_WR_IDLE: begin
                if (aw_hs && w_hs) begin
                    wr_st_d = TSL_WR_RESP;
                end else if (aw_hs) begin
                    wr_st_d = TSL_WR_ADDR;
                end else if (w_hs) begin
                    wr_st_d = TSL_WR_DATA;
                end else begin
                    wr_st_d = TSL_WR_IDLE;
                end
            end
            TSL_WR_ADDR: begin
                wr_st_d = w_hs ? TSL_WR_RESP : TSL_WR_ADDR;
            end
            TSL_WR_DATA: begin
                wr_st_d = aw_hs ? TSL_WR_RESP : TSL_WR_DATA;
            end
            default: begin
                wr_st_d = s_axi_bready ? TSL_WR_IDLE : TSL_WR_RESP;
            end
        endcase
    end

    // The write lands in the cycle in which its second half is taken.
    assign wr_go   = (wr_st_d == TSL_WR_RESP) && (wr_st_q != TSL_WR_RESP);
    assign wr_addr = aw_hs ? s_axi_awaddr : waddr_q;
    assign wr_data = w_hs ? s_axi_wdata : wdata_q;
    assign wr_strb = w_hs ? s_axi_wstrb : wstrb_q;
    assign w_ctrl  = wr_go && (wr_addr == `TSL_OFF_CTRL);
    assign w_slot  = wr_go && (wr_addr == `TSL_OFF_SLOT);
    assign w_txd   = wr_go && (wr_addr == `TSL_OFF_TXD);
    assign w_rxs   = wr_go && (wr_addr == `TSL_OFF_RXS);
    assign w_map   = w_ctrl || w_slot || w_txd || w_rxs;

    // Write channel registers.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wr_st_q <= TSL_WR_IDLE;
            waddr_q <= '0;
            wdata_q <= 32'h00000000;
            wstrb_q <= 4'h0;
            bresp_q <= `TSL_RESP_OKAY;
        end else begin
            wr_st_q <= wr_st_d;
            if (aw_hs) waddr_q <= s_axi_awaddr;
            if (w_hs) wdata_q <= s_axi_wdata;
            if (w_hs) wstrb_q <= s_axi_wstrb;
            if (wr_go) bresp_q <= w_map ? `TSL_RESP_OKAY : `TSL_RESP_DECERR;
        end
    end

    // Read decode; unmapped addresses return zero with a decode error.
    always_comb begin
        rd_data = 32'h00000000;
        rd_resp = `TSL_RESP_OKAY;
        if (s_axi_araddr == `TSL_OFF_CTRL) begin
            rd_data = ctrl_q;
        end else if (s_axi_araddr == `TSL_OFF_SLOT) begin
            rd_data = slot_q;
        end else if (s_axi_araddr == `TSL_OFF_TXD) begin
            rd_data = txd_q;
        end else if (s_axi_araddr == `TSL_OFF_RXS) begin
            rd_data = {14'h0000, ovr_q, new_q, 1'b0, rxs_slot_q, rxs_byte_q};
        end else begin
            rd_resp = `TSL_RESP_DECERR;
        end
    end

    // Read channel: one read outstanding, answered one cycle after it is taken.
    assign s_axi_arready = !rvalid_q;
    assign ar_hs         = s_axi_arvalid && s_axi_arready;
    assign s_axi_rvalid  = rvalid_q;
    assign s_axi_rdata   = rdata_q;
    assign s_axi_rresp   = rresp_q;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_q <= 1'b0;
            rdata_q  <= 32'h00000000;
            rresp_q  <= `TSL_RESP_OKAY;
        end else if (ar_hs) begin
            rvalid_q <= 1'b1;
            rdata_q  <= rd_data;
            rresp_q  <= rd_resp;
        end else if (s_axi_rready) begin
            rvalid_q <= 1'b0;
        end
    end

    // Configuration registers.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_q <= `TSL_CTRL_RST;
            slot_q <= `TSL_SLOT_RST;
            txd_q  <= `TSL_TXD_RST;
        end else begin
            if (w_ctrl) ctrl_q <= tsl_wmerge(ctrl_q, wr_data, wr_strb, `TSL_CTRL_MASK);
            if (w_slot) slot_q <= tsl_wmerge(slot_q, wr_data, wr_strb, `TSL_SLOT_MASK);
            if (w_txd) txd_q <= tsl_wmerge(txd_q, wr_data, wr_strb, `TSL_TXD_MASK);
        end
    end

    // Received bytes arrive as a toggle; the byte is stable when it is seen.
    assign rx_evt  = rx_tgl_s_q[1] ^ rx_tgl_s_q[2];
    assign clr_new = w_rxs && wr_strb[2] && wr_data[`TSL_B_NEW];
    assign clr_ovr = w_rxs && wr_strb[2] && wr_data[`TSL_B_OVR];

    // Sticky flags: a new byte wins over a clear in the same cycle.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rx_tgl_s_q <= 3'h0;
            rxs_byte_q <= 8'h00;
            rxs_slot_q <= 7'h00;
            new_q      <= 1'b0;
            ovr_q      <= 1'b0;
        end else begin
            rx_tgl_s_q <= {rx_tgl_s_q[1:0], rx_tgl_q};
            if (rx_evt) rxs_byte_q <= rx_byte_q;
            if (rx_evt) rxs_slot_q <= rx_slot_q;
            new_q <= rx_evt || (new_q && !clr_new);
            ovr_q <= (rx_evt && new_q && !clr_new) || (ovr_q && !clr_ovr);
        end
    end

    // Transmit clock source: codes 0-7 pick a receive clock, 8-11 a reference.
    assign clk_sel          = ctrl_q[`TSL_F_CLKSEL];
    assign tx_src_clk       = clk_sel[3] ? dejittered_ref_clock[clk_sel[1:0]]
                                         : rx_link_clock[clk_sel[2:0]];
    assign tx_link_clock_o  = tx_src_clk;
    assign tx_link_clock_oe = ctrl_q[`TSL_B_CLKOUT];

    // The pin is taken as the clock when it is an input; inversion picks the edge.
    assign tx_line_clock = (ctrl_q[`TSL_B_CLKOUT] ? tx_src_clk : tx_link_clock_i)
                           ^ ctrl_q[`TSL_B_CLKNEG];
    assign rx_line_clock = rx_link_clock[`TSL_OWN_RX];

    // Transmit direction configuration, crossed by its framer.
    assign tx_frm.cfg = '{
        en:        ctrl_q[`TSL_B_EN],
        pulse_out: ctrl_q[`TSL_B_POUT],
        generic:   ctrl_q[`TSL_B_GENERIC],
        pol_high:  ctrl_q[`TSL_B_TXPOL],
        len:       ctrl_q[`TSL_F_TXLEN],
        first:     slot_q[`TSL_F_FIRST],
        last:      slot_q[`TSL_F_LAST],
        data:      txd_q[7:0]
    };
    assign tx_frm.pulse_in = tx_frame_pulse_pin_i;

    // Receive frame length follows the expected receive clock rate.
    assign rx_frm.cfg = '{
        en:        ctrl_q[`TSL_B_EN],
        pulse_out: 1'b0,
        generic:   ctrl_q[`TSL_B_GENERIC],
        pol_high:  ctrl_q[`TSL_B_RXPOL],
        len:       ctrl_q[`TSL_F_RXRATE],
        first:     slot_q[`TSL_F_FIRST],
        last:      slot_q[`TSL_F_LAST],
        data:      8'h00
    };
    assign rx_frm.pulse_in = rx_frame_pulse_pin;

    tsl_framer u_tx_framer (
        .clk     (tx_line_clock),
        .aresetn (aresetn),
        .frm     (tx_frm.framer)
    );

    tsl_framer u_rx_framer (
        .clk     (rx_line_clock),
        .aresetn (aresetn),
        .frm     (rx_frm.framer)
    );

    // Transmit side: most significant bit first, driven only in assigned slots.
    always_ff @(posedge tx_line_clock) begin
        if (!tx_frm.rst_n) begin
            tx_do_q <= 1'b0;
            tx_oe_q <= 1'b0;
            fp_oe_q <= 1'b0;
        end else begin
            tx_do_q <= tx_frm.scfg.data[~tx_frm.cnt_d[2:0]];
            tx_oe_q <= tsl_in_window(tx_frm.cnt_d, tx_frm.scfg);
            fp_oe_q <= tx_frm.scfg.en && tx_frm.scfg.pulse_out;
        end
    end

    assign tdm_tx_serial_out_o   = tx_do_q;
    assign tdm_tx_serial_out_oe  = tx_oe_q;
    assign tx_frame_pulse_pin_o  = tx_frm.pulse_q;
    assign tx_frame_pulse_pin_oe = fp_oe_q;

    // Receive side: assemble bytes of assigned slots and hand each one over.
    always_ff @(posedge rx_line_clock) begin
        if (!rx_frm.rst_n) begin
            rx_sh_q   <= 8'h00;
            rx_byte_q <= 8'h00;
            rx_slot_q <= 7'h00;
            rx_tgl_q  <= 1'b0;
        end else if (tsl_in_window(rx_frm.cnt_q, rx_frm.scfg)) begin
            rx_sh_q <= {rx_sh_q[6:0], tdm_rx_serial_in};
            if (rx_frm.cnt_q[2:0] == 3'h7) begin
                rx_byte_q <= {rx_sh_q[6:0], tdm_rx_serial_in};
                rx_slot_q <= rx_frm.cnt_q[9:3];
                rx_tgl_q  <= ~rx_tgl_q;
            end
        end
    end

endmodule

// ---- tb/tsl_port_checker.sv ----
`timescale 1ns/100ps
`include "tsl_defs.svh"

// Watches bus answers and the transmit clock pin direction.
module tsl_port_checker (
    input wire logic               aclk,
    input wire logic               aresetn,
    input wire logic [`TSL_AW-1:0] s_axi_awaddr,
    input wire logic               s_axi_awvalid,
    input wire logic               s_axi_awready,
    input wire logic [31:0]        s_axi_wdata,
    input wire logic [3:0]         s_axi_wstrb,
    input wire logic               s_axi_wvalid,
    input wire logic               s_axi_wready,
    input wire logic [1:0]         s_axi_bresp,
    input wire logic               s_axi_bvalid,
    input wire logic               s_axi_bready,
    input wire logic [`TSL_AW-1:0] s_axi_araddr,
    input wire logic               s_axi_arvalid,
    input wire logic               s_axi_arready,
    input wire logic [31:0]        s_axi_rdata,
    input wire logic [1:0]         s_axi_rresp,
    input wire logic               s_axi_rvalid,
    input wire logic               s_axi_rready,
    input wire logic               tx_link_clock_oe
);
    // Unmapped offsets must answer with a decode error.
    wire bad_w = !(s_axi_awaddr inside {6'h00, 6'h04, 6'h08, 6'h0c});
    wire bad_r = !(s_axi_araddr inside {6'h00, 6'h04, 6'h08, 6'h0c});
    wire ctl_w = (s_axi_awaddr == `TSL_OFF_CTRL) && s_axi_wstrb[0];

    default clocking @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    // Write address and data taken at one edge.
    sequence wr_take;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence rd_take;
        s_axi_arvalid && s_axi_arready;
    endsequence

    AST_WR_ANSWER: assert property (wr_take |=> s_axi_bvalid)
        else $error("write response late");
    AST_B_STAND: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped");
    AST_RD_ANSWER: assert property (rd_take |=> s_axi_rvalid)
        else $error("read data late");
    AST_R_STAND: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped");
    AST_AR_BLOCK: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken during answer");
    AST_RD_DECERR: assert property (rd_take ##0 bad_r |=> s_axi_rresp == 2'h3 && s_axi_rdata == 32'h0)
        else $error("unmapped read answered");
    AST_WR_DECERR: assert property (wr_take ##0 bad_w |=> s_axi_bresp == 2'h3)
        else $error("unmapped write answered");
    AST_CLK_OUT: assert property (wr_take ##0 (ctl_w && s_axi_wdata[1]) |=> tx_link_clock_oe)
        else $error("clock pin not driven");
    AST_CLK_IN: assert property (wr_take ##0 (ctl_w && !s_axi_wdata[1]) |=> !tx_link_clock_oe)
        else $error("clock pin still driven");
endmodule

bind tsl_port tsl_port_checker i_chk (.*);

// ---- tb/tsl_far_end.sv ----
`timescale 1ns/100ps

// Far end: line and reference clocks and a framed receive stream.
module tsl_far_end (
    output logic [7:0] rx_link_clock,
    output logic [3:0] dejittered_ref_clock,
    output logic       tx_link_clock_i,
    output logic       tdm_rx_serial_in,
    output logic       rx_frame_pulse_pin,
    input  wire logic       rx_act,
    input  wire logic [9:0] rx_last
);
    logic [11:0] src_clk = 12'h000;
    logic        txc     = 1'b0;
    logic [9:0]  bit_q   = 10'h000;
    wire  [7:0]  pat     = 8'ha5 ^ {1'b0, bit_q[9:3]};

    // Clocks of distinct rates, offset so no edge meets the system clock.
    for (genvar i = 0; i < 12; i++) begin : g_clk
        initial begin
            #(1.3 + i);
            forever #(80 + 4 * i) src_clk[i] = !src_clk[i];
        end
    end

    // Clock offered to a listening transmit clock pin.
    initial forever #90.7 txc = !txc;

    // Bits move on the falling edge, steady at the rising one.
    always @(negedge src_clk[0]) begin
        bit_q <= (bit_q == rx_last) ? 10'h000 : bit_q + 10'h001;
    end

    // Each slot carries its own byte, MSB first; the pulse marks the last bit.
    assign rx_link_clock        = src_clk[7:0];
    assign dejittered_ref_clock = src_clk[11:8];
    assign tx_link_clock_i      = txc;
    assign rx_frame_pulse_pin   = (bit_q == rx_last) ? rx_act : !rx_act;
    assign tdm_rx_serial_in     = pat[3'h7 - bit_q[2:0]];
endmodule

// ---- tb/testbench.sv ----
`timescale 1ns/100ps
`include "tsl_defs.svh"

module testbench;
    import tsl_pkg::*;
    logic aclk = 1'b0, aresetn = 1'b0;
    logic [5:0]  s_axi_awaddr = 6'h00, s_axi_araddr = 6'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, d;
    logic [3:0]  s_axi_wstrb = 4'hf;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, resp;
    logic [7:0] rx_link_clock;
    logic [3:0] dejittered_ref_clock;
    logic tdm_rx_serial_in, rx_frame_pulse_pin, tx_link_clock_i, tx_link_clock_o;
    logic tx_link_clock_oe, tx_frame_pulse_pin_o, tx_frame_pulse_pin_oe;
    logic tdm_tx_serial_out_o, tdm_tx_serial_out_oe;
    logic tx_frame_pulse_pin_i = 1'b1, rx_act = 1'b0;
    logic [9:0] rx_last = 10'h0ff;
    wire  [11:0] clk12 = {dejittered_ref_clock, rx_link_clock};
    logic [5:0]  r_off [3] = '{`TSL_OFF_CTRL, `TSL_OFF_SLOT, `TSL_OFF_TXD};
    logic [31:0] r_rst [3] = '{`TSL_CTRL_RST, `TSL_SLOT_RST, `TSL_TXD_RST};
    logic [31:0] r_msk [3] = '{`TSL_CTRL_MASK, `TSL_SLOT_MASK, `TSL_TXD_MASK};
    int errors = 0, n_checks = 0;

    tsl_port i_dut (.*);
    tsl_far_end i_far (.*);

    // System clock.
    always #4 aclk = !aclk;

    // Compares one value and counts the outcome.
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // Bus write; valids drop when taken, bready rises a cycle after they drop.
    task automatic wr(input logic [5:0] a, input logic [31:0] v);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (s_axi_awvalid || s_axi_wvalid);
        s_axi_bready <= 1'b1;
        do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
        resp = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask

    // Bus read; rready rises a cycle late.
    task automatic rd(input logic [5:0] a, output logic [31:0] v);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do @(posedge aclk); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        @(posedge aclk);
        s_axi_rready <= 1'b1;
        do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
        v = s_axi_rdata;
        resp = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask

    // Changes config with the link off, then waits.
    task automatic set_ctrl(input logic [31:0] c);
        wr(`TSL_OFF_CTRL, c & 32'hfffffffe);
        repeat (200) @(posedge aclk);
        wr(`TSL_OFF_CTRL, c);
        repeat (200) @(posedge aclk);
    endtask

    // Checks one transmit frame from its generated pulse.
    task automatic run_tx(input logic [31:0] c, input logic lv, neg, input int nb);
        set_ctrl(c);
        wait (tx_frame_pulse_pin_o !== lv);
        wait (tx_frame_pulse_pin_o === lv);
        for (int i = 0; i < nb; i++) begin
            if (neg) @(negedge clk12[c[15:12]]);
            else @(posedge clk12[c[15:12]]);
            #1;
            chk("tx oe", tdm_tx_serial_out_oe, (i / 8) == 2);
            if (tdm_tx_serial_out_oe) chk("tx bit", tdm_tx_serial_out_o, 8'h3c >> (7 - i % 8) & 1);
            chk("tx pulse", tx_frame_pulse_pin_o, (i == nb - 1) ? lv : !lv);
        end
        chk("pulse oe", tx_frame_pulse_pin_oe, 1'b1);
    endtask

    // Receives two frames and reads the assigned slot's byte.
    task automatic run_rx(input logic [31:0] c, input logic act, input logic [9:0] last,
                          input logic [31:0] slot, input logic [16:0] exp);
        wr(`TSL_OFF_CTRL, 32'h0);
        rx_act <= act;
        rx_last <= last;
        wr(`TSL_OFF_SLOT, slot);
        wr(`TSL_OFF_RXS, 32'h00030000);
        set_ctrl(c);
        repeat (2 * last + 20) @(posedge rx_link_clock[0]);
        rd(`TSL_OFF_RXS, d);
        chk("rx byte", d[16:0], exp);
    endtask

    task automatic test_done();
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // Watchdog above the longest expected run.
    initial begin
        repeat (95000) @(posedge aclk);
        errors++;
        test_done();
    end

    // Reset spans several link clock edges as well.
    initial begin
        repeat (20) @(posedge rx_link_clock[0]);
        @(posedge aclk);
        aresetn <= 1'b1;
        for (int k = 0; k < 3; k++) begin
            rd(r_off[k], d);
            chk("reset value", d, r_rst[k]);
            wr(r_off[k], 32'hffffffff);
            rd(r_off[k], d);
            chk("writable bits", d, r_msk[k]);
        end
        wr(6'h10, 32'h0);
        chk("write resp", resp, `TSL_RESP_DECERR);
        rd(6'h10, d);
        chk("read resp", resp, `TSL_RESP_DECERR);
        chk("read data", d, 32'h0);
        for (int n = 0; n < 12; n++) begin
            wr(`TSL_OFF_CTRL, {16'h0000, n[3:0], 12'h002});
            chk("clock dir", tx_link_clock_oe, 1'b1);
            repeat (20) #7 chk("tx clock", tx_link_clock_o, clk12[n]);
        end
        wr(`TSL_OFF_SLOT, 32'h00000202);
        wr(`TSL_OFF_TXD, 32'h0000003c);
        run_tx(32'h0000000b, 1'b0, 1'b0, 256);
        run_tx(32'h0000913f, 1'b1, 1'b1, 512);
        run_rx(32'h00000001, 1'b0, 10'h0ff, 32'h00000202, 17'h102a7);
        run_rx(32'h00000451, 1'b1, 10'h1ff, 32'h00002828, 17'h1288d);
        test_done();
    end
endmodule
